/* ata_mode_pin_config_decode.sv */
// latch and decode of the transfer-mode and pin configuration bytes
`timescale 1ns/1ps
module ata_mode_pin_config_decode (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // configuration memory byte stream
    input wire logic cfg_wr,
    input wire logic [7:0] cfg_addr,
    input wire logic [7:0] cfg_data,
    input wire logic cfg_done,
    output logic cfg_ready,
    // drive capabilities from identify data
    input wire logic drive_is_packet,
    input wire logic [5:0] drive_udma_support,
    input wire logic drive_mwdma_support,
    input wire logic [1:0] drive_pio_support,
    // selected transfer mode
    output cfg_decode_pkg::xfer_kind_t xfer_kind,
    output logic [2:0] udma_mode,
    output logic [2:0] pio_mode,
    output logic udma_mask_illegal,
    // strategy flags
    output logic fixed_drive_search_enable,
    output logic large_package_select,
    output logic removable_master_enable,
    // pin controls
    input wire logic bus_share_enable_input,
    output logic ata_drive_enable,
    input wire logic disk_ready,
    output logic disk_ready_output,
    input wire logic usb_high_speed,
    input wire logic gpio2_out_value,
    input wire logic gpio2_oe,
    output logic gp_pin2_speed_indicator,
    input wire logic ata_pullup_enable_pin,
    input wire logic high_power_pin,
    input wire logic drive_power_valid_input,
    output logic button_mode,
    output logic [2:0] endpoint1_in_data,
    output logic drive_power_present
);
    import cfg_decode_pkg::*;

    // every check below runs on the one clock and is off during reset
    default clocking chk_clk @(posedge ref_clk);
    endclocking
    default disable iff (rst);

    logic [7:0] udma_transfer_config;
    logic [7:0] pio_dma_mode_config;
    logic [7:0] pin_behaviour_config;
    logic loaded;
    logic [7:0] next_udma_transfer_config;
    logic [7:0] next_pio_dma_mode_config;
    logic [7:0] next_pin_behaviour_config;
    logic next_loaded;

    // writes are accepted only before the load completes; later traffic
    // on the stream cannot disturb a drive already configured
    always_comb begin
        next_udma_transfer_config = udma_transfer_config;
        next_pio_dma_mode_config = pio_dma_mode_config;
        next_pin_behaviour_config = pin_behaviour_config;
        next_loaded = loaded | cfg_done;
        if (!loaded && cfg_wr) begin
            if (cfg_addr == ADDR_UDMA_CFG) begin
                next_udma_transfer_config = cfg_data;
            end else if (cfg_addr == ADDR_PIO_DMA_CFG) begin
                next_pio_dma_mode_config = cfg_data;
            end else if (cfg_addr == ADDR_PIN_CFG) begin
                next_pin_behaviour_config = cfg_data;
            end
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            udma_transfer_config <= RST_UDMA_CFG;
            pio_dma_mode_config <= RST_PIO_DMA_CFG;
            pin_behaviour_config <= RST_PIN_CFG;
            loaded <= 1'b0;
        end else begin
            udma_transfer_config <= next_udma_transfer_config;
            pio_dma_mode_config <= next_pio_dma_mode_config;
            pin_behaviour_config <= next_pin_behaviour_config;
            loaded <= next_loaded;
        end
    end

    assign cfg_ready = loaded;

    // transfer mode decode
    logic udma_allowed;
    logic udma_found;
    logic [2:0] udma_pick;
    logic [1:0] pio_both;
    xfer_kind_t next_xfer_kind;
    logic [2:0] next_udma_mode;
    logic [2:0] next_pio_mode;
    logic next_udma_mask_illegal;

    assign udma_allowed = drive_is_packet ?
        udma_transfer_config[BIT_UDMA_ATAPI] :
        udma_transfer_config[BIT_UDMA_ATA];

    // reserved mask bits are ignored, so a bad memory image degrades
    // to the legal modes instead of an unsupported timing
    udma_mode_pick #(
        .WIDTH(6)
    ) u_pick (
        .enabled(udma_transfer_config[5:0] & UDMA_LEGAL_MASK),
        .supported(drive_udma_support),
        .found(udma_found),
        .mode(udma_pick)
    );

    assign pio_both = pio_dma_mode_config[1:0] & drive_pio_support;

    always_comb begin
        next_pio_mode = PIO_MODE0;
        if (pio_both[BIT_PIO4]) begin
            next_pio_mode = PIO_MODE4;
        end else if (pio_both[BIT_PIO3]) begin
            next_pio_mode = PIO_MODE3;
        end
        next_udma_mask_illegal =
            |(udma_transfer_config[5:0] & ~UDMA_LEGAL_MASK);
        next_udma_mode = 3'h0;
        next_xfer_kind = XFER_PIO;
        if (!loaded) begin
            next_xfer_kind = XFER_PIO;
        end else if (udma_allowed && udma_found) begin
            next_xfer_kind = XFER_UDMA;
            next_udma_mode = udma_pick;
        end else if (pio_dma_mode_config[BIT_MWDMA] &&
                     drive_mwdma_support) begin
            next_xfer_kind = XFER_MWDMA;
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            xfer_kind <= XFER_PIO;
            udma_mode <= 3'h0;
            pio_mode <= PIO_MODE0;
            udma_mask_illegal <= 1'b0;
        end else begin
            xfer_kind <= next_xfer_kind;
            udma_mode <= next_udma_mode;
            pio_mode <= next_pio_mode;
            udma_mask_illegal <= next_udma_mask_illegal;
        end
    end

    // pin behaviour, registered so every output comes from a flop
    logic dpv_active;
    assign dpv_active = pin_behaviour_config[BIT_DPV_POL] ?
        drive_power_valid_input : ~drive_power_valid_input;

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            fixed_drive_search_enable <= 1'b0;
            large_package_select <= 1'b0;
            removable_master_enable <= 1'b0;
            ata_drive_enable <= 1'b0;
            disk_ready_output <= 1'b1;
            gp_pin2_speed_indicator <= 1'b0;
            button_mode <= 1'b0;
            endpoint1_in_data <= 3'h0;
            drive_power_present <= 1'b0;
        end else begin
            fixed_drive_search_enable <=
                pin_behaviour_config[BIT_SEARCH];
            large_package_select <= pin_behaviour_config[BIT_BIGPKG];
            removable_master_enable <=
                pin_behaviour_config[BIT_DPV_EN];
            ata_drive_enable <= bus_share_enable_input |
                pin_behaviour_config[BIT_SHARE];
            disk_ready_output <= pin_behaviour_config[BIT_RDY_POL] ?
                disk_ready : ~disk_ready;
            gp_pin2_speed_indicator <=
                (pin_behaviour_config[BIT_HS_IND] && gpio2_oe) ?
                usb_high_speed : gpio2_out_value;
            button_mode <= pin_behaviour_config[BIT_BUTTON];
            endpoint1_in_data <= pin_behaviour_config[BIT_BUTTON] ?
                {ata_pullup_enable_pin, high_power_pin,
                 drive_power_valid_input} : 3'h0;
            drive_power_present <= pin_behaviour_config[BIT_DPV_EN] &
                dpv_active;
        end
    end

    // ultra dma is picked only once loaded, gated and with a common mode
    sequence s_udma_eligible;
        loaded && udma_allowed && udma_found;
    endsequence

    AST_HOLD_AFTER_LOAD: assert property (
        loaded |=> $stable(pin_behaviour_config)
        && $stable(udma_transfer_config) && $stable(pio_dma_mode_config))
        else $error("latched bytes changed after load");
    AST_PIO_UNTIL_LOADED: assert property (
        !loaded |=> xfer_kind == XFER_PIO)
        else $error("dma chosen before load");
    AST_UDMA_ATA_GATE: assert property (
        (!drive_is_packet && !udma_transfer_config[BIT_UDMA_ATA])
        |=> xfer_kind != XFER_UDMA)
        else $error("udma used with non-packet drive while off");
    AST_UDMA_ATAPI_GATE: assert property (
        (drive_is_packet && !udma_transfer_config[BIT_UDMA_ATAPI])
        |=> xfer_kind != XFER_UDMA)
        else $error("udma used with packet drive while off");
    AST_UDMA_MODE4: assert property (
        (s_udma_eligible ##0
         (udma_transfer_config[4] && drive_udma_support[4]))
        |=> xfer_kind == XFER_UDMA && udma_mode == 3'h4)
        else $error("udma mode 4 not chosen");
    AST_UDMA_MODE2: assert property (
        (s_udma_eligible ##0
         !(udma_transfer_config[4] && drive_udma_support[4]))
        |=> xfer_kind == XFER_UDMA && udma_mode == 3'h2)
        else $error("udma mode 2 not chosen");
    AST_NO_RESERVED_UDMA: assert property (
        xfer_kind == XFER_UDMA |-> (udma_mode == 3'h4 || udma_mode == 3'h2))
        else $error("reserved udma mode used");
    AST_MWDMA: assert property (
        (loaded && !(udma_allowed && udma_found)
         && pio_dma_mode_config[BIT_MWDMA] && drive_mwdma_support)
        |=> xfer_kind == XFER_MWDMA)
        else $error("multiword dma not chosen");
    AST_PIO_HIGHEST: assert property (
        pio_both[BIT_PIO4] |=> pio_mode == PIO_MODE4)
        else $error("pio mode 4 not chosen");
    AST_PIO_FALLBACK: assert property (
        pio_both == 2'h0 |=> pio_mode == PIO_MODE0)
        else $error("pio fallback not mode 0");
    AST_SHARE: assert property (
        (!bus_share_enable_input && !pin_behaviour_config[BIT_SHARE])
        |=> !ata_drive_enable)
        else $error("ata driven while sharing off");
    AST_RDY_POL: assert property (
        1'b1 |=> disk_ready_output ==
        ($past(disk_ready) ~^ $past(pin_behaviour_config[BIT_RDY_POL])))
        else $error("disk ready polarity wrong");
    AST_BUTTONS: assert property (
        !pin_behaviour_config[BIT_BUTTON] |=> endpoint1_in_data == 3'h0)
        else $error("buttons reported while off");
    AST_DPV_OFF: assert property (
        !pin_behaviour_config[BIT_DPV_EN] |=> !drive_power_present)
        else $error("power valid used while disabled");
endmodule : ata_mode_pin_config_decode

/* cfg_decode_pkg.sv */
// constants for the transfer-mode and pin configuration decode
package cfg_decode_pkg;
    // configuration memory byte addresses
    localparam logic [7:0] ADDR_UDMA_CFG = 8'h06;
    localparam logic [7:0] ADDR_PIO_DMA_CFG = 8'h07;
    localparam logic [7:0] ADDR_PIN_CFG = 8'h08;
    // reset values of the latched bytes (all features off)
    localparam logic [7:0] RST_UDMA_CFG = 8'h00;
    localparam logic [7:0] RST_PIO_DMA_CFG = 8'h00;
    localparam logic [7:0] RST_PIN_CFG = 8'h00;
    // transfer-mode byte fields
    localparam int BIT_UDMA_ATA = 7;
    localparam int BIT_UDMA_ATAPI = 6;
    localparam logic [5:0] UDMA_LEGAL_MASK = 6'h14;
    // second mode byte fields
    localparam int BIT_MWDMA = 2;
    localparam int BIT_PIO4 = 1;
    localparam int BIT_PIO3 = 0;
    // pin byte fields
    localparam int BIT_BUTTON = 7;
    localparam int BIT_SEARCH = 6;
    localparam int BIT_BIGPKG = 5;
    localparam int BIT_SHARE = 4;
    localparam int BIT_RDY_POL = 3;
    localparam int BIT_HS_IND = 2;
    localparam int BIT_DPV_POL = 1;
    localparam int BIT_DPV_EN = 0;
    // pio mode codes reported out
    localparam logic [2:0] PIO_MODE0 = 3'h0;
    localparam logic [2:0] PIO_MODE3 = 3'h3;
    localparam logic [2:0] PIO_MODE4 = 3'h4;
    typedef enum logic [1:0] {XFER_PIO, XFER_MWDMA, XFER_UDMA} xfer_kind_t;
endpackage : cfg_decode_pkg

/* udma_mode_pick.sv */
// picks the highest ultra dma mode enabled and supported
`timescale 1ns/1ps
module udma_mode_pick #(
    parameter int WIDTH = 6
) (
    // candidate modes
    input wire logic [WIDTH-1:0] enabled,
    input wire logic [WIDTH-1:0] supported,
    // result
    output logic found,
    output logic [2:0] mode
);
    // the mode code is three bits wide, so eight candidates at most
    if (WIDTH < 1 || WIDTH > 8) begin : g_bad_width
        $error("udma_mode_pick: WIDTH out of range");
    end

    logic [WIDTH-1:0] both;
    assign both = enabled & supported;

    // scan upward so the last hit, the highest mode, wins
    always_comb begin
        found = 1'b0;
        mode = 3'h0;
        for (int i = 0; i < WIDTH; i++) begin
            if (both[i]) begin
                found = 1'b1;
                mode = i[2:0];
            end
        end
    end
endmodule : udma_mode_pick

/* cfg_mem_model.sv */
// behavioural configuration memory loader streaming the decode bytes
`timescale 1ns/1ps
module cfg_mem_model (
    // clock
    input wire logic ref_clk,
    // byte stream
    output logic cfg_wr,
    output logic [7:0] cfg_addr,
    output logic [7:0] cfg_data,
    output logic cfg_done
);
    import cfg_decode_pkg::*;

    initial begin
        cfg_wr = 1'b0;
        cfg_addr = 8'h00;
        cfg_data = 8'h00;
        cfg_done = 1'b0;
    end

    // released lines show the inverse so a stale byte is never mistaken
    task automatic write_byte(input logic [7:0] a, input logic [7:0] d,
                              input logic last);
        @(negedge ref_clk);
        cfg_wr = 1'b1;
        cfg_addr = a;
        cfg_data = d;
        cfg_done = last;
        @(negedge ref_clk);
        cfg_wr = 1'b0;
        cfg_done = 1'b0;
        cfg_addr = ~a;
        cfg_data = ~d;
    endtask : write_byte

    // bad lets a scenario program reserved mask bits on purpose
    task automatic load(input logic [7:0] u, input logic [7:0] n,
                        input logic [7:0] p, input logic bad);
        write_byte(8'h09, ~p, 1'b0);
        write_byte(ADDR_UDMA_CFG, bad ? u : u & {2'b11, UDMA_LEGAL_MASK},
                   1'b0);
        write_byte(ADDR_PIO_DMA_CFG, n & 8'h07, 1'b0);
        // package bit is passed as the board strap sets it
        write_byte(ADDR_PIN_CFG, p, 1'b1);
    endtask : load
endmodule : cfg_mem_model

/* testbench.sv */
// self-checking bench for the mode and pin configuration decode
`timescale 1ns/1ps
module testbench;
    import cfg_decode_pkg::*;
    typedef struct {int due; logic [9:0] m; logic [10:0] p;} exp_t;
    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    logic cfg_wr, cfg_done, cfg_ready;
    logic [7:0] cfg_addr, cfg_data, ub, nb, pb;
    logic drive_is_packet = 1'b0, drive_mwdma_support = 1'b0;
    logic [5:0] drive_udma_support = 6'h00;
    logic [1:0] drive_pio_support = 2'h0;
    logic bus_share_enable_input = 1'b0, disk_ready = 1'b0;
    logic usb_high_speed = 1'b0, gpio2_out_value = 1'b0, gpio2_oe = 1'b0;
    logic ata_pullup_enable_pin = 1'b0, high_power_pin = 1'b0;
    logic drive_power_valid_input = 1'b0;
    xfer_kind_t xfer_kind;
    logic [2:0] udma_mode, pio_mode, endpoint1_in_data;
    logic udma_mask_illegal, fixed_drive_search_enable;
    logic large_package_select, removable_master_enable, ata_drive_enable;
    logic disk_ready_output, gp_pin2_speed_indicator, button_mode;
    logic drive_power_present;
    int cyc = 0;
    int n_tests = 0;
    int n_mismatch = 0;
    exp_t exp_q[$];

    ata_mode_pin_config_decode u_dut (.ref_clk, .rst, .cfg_wr, .cfg_addr,
        .cfg_data, .cfg_done, .cfg_ready, .drive_is_packet,
        .drive_udma_support, .drive_mwdma_support, .drive_pio_support,
        .xfer_kind, .udma_mode, .pio_mode, .udma_mask_illegal,
        .fixed_drive_search_enable, .large_package_select,
        .removable_master_enable, .bus_share_enable_input, .ata_drive_enable,
        .disk_ready, .disk_ready_output, .usb_high_speed, .gpio2_out_value,
        .gpio2_oe, .gp_pin2_speed_indicator, .ata_pullup_enable_pin,
        .high_power_pin, .drive_power_valid_input, .button_mode,
        .endpoint1_in_data, .drive_power_present);
    cfg_mem_model u_mem (.ref_clk, .cfg_wr, .cfg_addr, .cfg_data,
        .cfg_done);

    initial begin
        forever #4 ref_clk = ~ref_clk;
    end
    always @(posedge ref_clk) cyc <= cyc + 1;

    task automatic end_of_test();
        // a note never compared means a result that never showed
        n_mismatch += exp_q.size();
        $display("tests %0d mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : end_of_test

    task automatic chk_mode(input logic [9:0] ex);
        n_tests++;
        if (ex !== {xfer_kind, udma_mode, pio_mode, udma_mask_illegal,
                    cfg_ready}) begin
            n_mismatch++;
            $display("BAD mode exp %h got %h", ex, {xfer_kind, udma_mode,
                     pio_mode, udma_mask_illegal, cfg_ready});
        end
    endtask : chk_mode

    task automatic chk_pin(input logic [10:0] ex);
        logic [10:0] g;
        g = {fixed_drive_search_enable, large_package_select,
             removable_master_enable, ata_drive_enable, disk_ready_output,
             gp_pin2_speed_indicator, button_mode, endpoint1_in_data,
             drive_power_present};
        n_tests++;
        if (ex !== g) begin
            n_mismatch++;
            $display("BAD pins exp %h got %h", ex, g);
        end
    endtask : chk_pin

    function automatic exp_t predict();
        exp_t e;
        logic [5:0] um;
        logic [2:0] md, pm;
        xfer_kind_t k;
        um = ub[5:0] & UDMA_LEGAL_MASK & drive_udma_support;
        pm = (nb[1] & drive_pio_support[1]) ? PIO_MODE4 :
             (nb[0] & drive_pio_support[0]) ? PIO_MODE3 : PIO_MODE0;
        k = XFER_PIO;
        md = 3'h0;
        if ((drive_is_packet ? ub[6] : ub[7]) && um != 6'h00) begin
            k = XFER_UDMA;
            md = um[4] ? 3'h4 : 3'h2;
        end else if (nb[2] & drive_mwdma_support) begin
            k = XFER_MWDMA;
        end
        e.m = {k, md, pm, |(ub[5:0] & ~UDMA_LEGAL_MASK), 1'b1};
        e.p = {pb[6], pb[5], pb[0], bus_share_enable_input | pb[4],
               pb[3] ~^ disk_ready,
               (pb[2] & gpio2_oe) ? usb_high_speed : gpio2_out_value, pb[7],
               pb[7] ? {ata_pullup_enable_pin, high_power_pin,
                        drive_power_valid_input} : 3'h0,
               pb[0] & (pb[1] ~^ drive_power_valid_input)};
        e.due = cyc + 3;
        return e;
    endfunction : predict

    task automatic probe();
        logic [31:0] r;
        @(negedge ref_clk);
        r = $urandom;
        {drive_is_packet, drive_udma_support, drive_mwdma_support,
         drive_pio_support, bus_share_enable_input, disk_ready,
         usb_high_speed, gpio2_out_value, gpio2_oe, ata_pullup_enable_pin,
         high_power_pin, drive_power_valid_input} = r[17:0];
        exp_q.push_back(predict());
        repeat (3) @(negedge ref_clk);
    endtask : probe

    always @(negedge ref_clk) begin
        if (exp_q.size() > 0 && exp_q[0].due == cyc) begin
            chk_mode(exp_q[0].m);
            chk_pin(exp_q[0].p);
            void'(exp_q.pop_front());
        end
    end

    initial begin
        void'($urandom(72099));
        for (int t = 0; t < 24; t++) begin
            @(negedge ref_clk);
            rst = 1'b1;
            // reset values: pio only, ready output at its inactive level
            exp_q.push_back('{cyc + 1, {XFER_PIO, 6'h00, 2'b00},
                              {4'h0, 1'b1, 6'h00}});
            repeat (6) @(negedge ref_clk);
            rst = 1'b0;
            ub = 8'($urandom);
            nb = 8'($urandom);
            pb = 8'($urandom);
            u_mem.load(ub, nb, pb, t[0]);
            if (!t[0]) ub = ub & {2'b11, UDMA_LEGAL_MASK};
            nb = nb & 8'h07;
            for (int i = 0; i < 20 && cfg_ready !== 1'b1; i++)
                @(negedge ref_clk);
            repeat (8) probe();
            // late writes to the pin and udma addresses must leave the latched bytes alone
            u_mem.write_byte(ADDR_PIN_CFG, ~pb, 1'b0);
            u_mem.write_byte(ADDR_UDMA_CFG, ~ub, 1'b1);
            repeat (2) probe();
        end
        // let the checker take the last note before the verdict
        repeat (2) @(negedge ref_clk);
        end_of_test();
    end

    initial begin
        #100000;
        n_mismatch++;
        end_of_test();
    end
endmodule : testbench
